/* edpc_top.sv */
/*
  Energy detect power control: event counting, power state machine,
  wake pulse bursts and the energy detect control register.
  Assumes line detector outputs are asynchronous pins and that the
  register port strobes are single-cycle and synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module edpc_top
  import edpc_pkg::*;
#(
  parameter int IDLE_CYCLES = edpc_pkg::IDLE_RESET_CYCLES,
  parameter int PULSE_GAP   = edpc_pkg::PULSE_GAP_CYCLES
)
(
  input  wire logic                        clk,           // 20 MHz clock
  input  wire logic                        resetn,        // sync reset, active low
  input  wire logic                        edDataPin,     // data event from line detector
  input  wire logic                        edErrPin,      // error event from line detector
  input  wire logic                        lineEnergyPin, // energy present on line
  input  wire logic [edpc_pkg::ADDR_W-1:0] regAddr,       // register address
  input  wire logic                        regWrEn,       // write strobe
  input  wire logic                        regRdEn,       // read strobe
  input  wire logic [edpc_pkg::DATA_W-1:0] regWrData,     // write data
  output logic      [edpc_pkg::DATA_W-1:0] regRdData,     // read data
  output logic                             wakeState,     // transceiver powered up
  output logic                             edPulse        // energy detect pulse out
);

  import edpc_pkg::*;

  logic [2:0] syncA_reg, syncA_next;
  logic [2:0] syncB_reg, syncB_next;
  logic [1:0] prev_reg, prev_next;

  logic dataEv;
  logic errEv;
  logic energyLvl;

  always_comb
  begin
    syncA_next = {lineEnergyPin, edErrPin, edDataPin};
    syncB_next = syncA_reg;
    prev_next  = syncB_reg[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
      prev_reg  <= 2'h0;
    end
    else
    begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      prev_reg  <= prev_next;
    end
  end

  assign dataEv    = syncB_reg[0] & ~prev_reg[0];
  assign errEv     = syncB_reg[1] & ~prev_reg[1];
  assign energyLvl = syncB_reg[2];

  logic                enable_reg, enable_next;
  logic                autoWake_reg, autoWake_next;
  logic                autoSleep_reg, autoSleep_next;
  logic                manual_reg, manual_next;
  logic                burstDis_reg, burstDis_next;
  logic [THR_W-1:0]    errThr_reg, errThr_next;
  logic [THR_W-1:0]    dataThr_reg, dataThr_next;
  logic                errHit_reg, errHit_next;
  logic                dataHit_reg, dataHit_next;
  logic [DATA_W-1:0]   rdData_reg, rdData_next;
  edpc_state_t         state_reg, state_next;
  logic [2:0]          burstLeft_reg, burstLeft_next;
  logic [15:0]         gapCnt_reg, gapCnt_next;
  logic                edPulse_reg, edPulse_next;
  logic [31:0]         idleCnt_reg, idleCnt_next;

  logic                wr;
  logic                rd;
  logic                idleTimeout;
  logic                clearCnt;
  logic                dataReach;
  logic                errReach;
  logic [THR_W-1:0]    dataCount;
  logic [THR_W-1:0]    errCount;
  logic [DATA_W-1:0]   regValue;

  assign wr          = regWrEn && (regAddr == EDC_ADDR);
  assign rd          = regRdEn && (regAddr == EDC_ADDR);
  assign idleTimeout = (idleCnt_reg == 32'(IDLE_CYCLES - 1));
  assign clearCnt    = !enable_reg || idleTimeout;

  edpc_event_counter #(.WIDTH(THR_W)) dataCounter
  (
    .clk       (clk),
    .resetn    (resetn),
    .clear     (clearCnt),
    .eventIn   (dataEv),
    .threshold (dataThr_reg),
    .count     (dataCount),
    .reach     (dataReach)
  );

  edpc_event_counter #(.WIDTH(THR_W)) errCounter
  (
    .clk       (clk),
    .resetn    (resetn),
    .clear     (clearCnt),
    .eventIn   (errEv),
    .threshold (errThr_reg),
    .count     (errCount),
    .reach     (errReach)
  );

  always_comb
  begin
    regValue = '0;
    regValue[EN_BIT]         = enable_reg;
    regValue[AUTO_WAKE_BIT]  = autoWake_reg;
    regValue[AUTO_SLEEP_BIT] = autoSleep_reg;
    regValue[MAN_BIT]        = manual_reg;
    regValue[BURST_DIS_BIT]  = burstDis_reg;
    regValue[STATE_BIT]      = (state_reg == ST_AWAKE);
    regValue[ERR_HIT_BIT]    = errHit_reg;
    regValue[DATA_HIT_BIT]   = dataHit_reg;
    regValue[ERR_THR_MSB:ERR_THR_LSB]   = errThr_reg;
    regValue[DATA_THR_MSB:DATA_THR_LSB] = dataThr_reg;
  end

  always_comb
  begin
    enable_next    = enable_reg;
    autoWake_next  = autoWake_reg;
    autoSleep_next = autoSleep_reg;
    burstDis_next  = burstDis_reg;
    errThr_next    = errThr_reg;
    dataThr_next   = dataThr_reg;
    manual_next    = 1'b0;
    if (wr)
    begin
      enable_next    = regWrData[EN_BIT];
      autoWake_next  = regWrData[AUTO_WAKE_BIT];
      autoSleep_next = regWrData[AUTO_SLEEP_BIT];
      manual_next    = regWrData[MAN_BIT];
      burstDis_next  = regWrData[BURST_DIS_BIT];
      errThr_next    = regWrData[ERR_THR_MSB:ERR_THR_LSB];
      dataThr_next   = regWrData[DATA_THR_MSB:DATA_THR_LSB];
    end
    // set beats clear-on-read
    errHit_next  = errReach | (errHit_reg & ~rd);
    dataHit_next = dataReach | (dataHit_reg & ~rd);
    if (rd)
      rdData_next = regValue;
    else if (regRdEn)
      rdData_next = '0;
    else
      rdData_next = rdData_reg;
    if (dataEv || !enable_reg || idleTimeout)
      idleCnt_next = '0;
    else
      idleCnt_next = idleCnt_reg + 32'h1;
  end

  always_comb
  begin
    state_next     = state_reg;
    burstLeft_next = burstLeft_reg;
    gapCnt_next    = gapCnt_reg;
    edPulse_next   = 1'b0;
    if (state_reg == ST_AWAKE && burstLeft_reg != 3'h0)
    begin
      if (gapCnt_reg == 16'h0)
      begin
        edPulse_next   = 1'b1;
        burstLeft_next = burstLeft_reg - 3'h1;
        gapCnt_next    = 16'(PULSE_GAP);
      end
      else
        gapCnt_next = gapCnt_reg - 16'h1;
    end
    if (enable_reg)
    begin
      case (state_reg)
        ST_ASLEEP:
        begin
          if (manual_reg || (autoWake_reg && dataReach))
          begin
            state_next     = ST_AWAKE;
            burstLeft_next = burstDis_reg ? BURST_SINGLE : BURST_FULL;
            gapCnt_next    = 16'h0;
          end
        end
        ST_AWAKE:
        begin
          if (manual_reg || (autoSleep_reg && !energyLvl))
          begin
            state_next     = ST_ASLEEP;
            burstLeft_next = 3'h0;
          end
        end
        default:
          state_next = ST_ASLEEP;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      enable_reg    <= EN_RST;
      autoWake_reg  <= AUTO_WAKE_RST;
      autoSleep_reg <= AUTO_SLEEP_RST;
      manual_reg    <= 1'b0;
      burstDis_reg  <= BURST_DIS_RST;
      errThr_reg    <= ERR_THR_RST;
      dataThr_reg   <= DATA_THR_RST;
      errHit_reg    <= 1'b0;
      dataHit_reg   <= 1'b0;
      rdData_reg    <= '0;
      idleCnt_reg   <= '0;
      state_reg     <= ST_ASLEEP;
      burstLeft_reg <= 3'h0;
      gapCnt_reg    <= 16'h0;
      edPulse_reg   <= 1'b0;
    end
    else
    begin
      enable_reg    <= enable_next;
      autoWake_reg  <= autoWake_next;
      autoSleep_reg <= autoSleep_next;
      manual_reg    <= manual_next;
      burstDis_reg  <= burstDis_next;
      errThr_reg    <= errThr_next;
      dataThr_reg   <= dataThr_next;
      errHit_reg    <= errHit_next;
      dataHit_reg   <= dataHit_next;
      rdData_reg    <= rdData_next;
      idleCnt_reg   <= idleCnt_next;
      state_reg     <= state_next;
      burstLeft_reg <= burstLeft_next;
      gapCnt_reg    <= gapCnt_next;
      edPulse_reg   <= edPulse_next;
    end
  end

  assign regRdData = rdData_reg;
  assign wakeState = (state_reg == ST_AWAKE);
  assign edPulse   = edPulse_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence wakeRise;
    $rose(wakeState);
  endsequence

  sequence firstPulse;
    ##1 edPulse;
  endsequence

  disabled_hold_a: assert property (!enable_reg |=> $stable(wakeState))
    else $error("power state moved while disabled");
  auto_wake_a: assert property (enable_reg && !wakeState && autoWake_reg && dataReach |=> wakeState)
    else $error("no wake on data threshold");
  auto_sleep_a: assert property (enable_reg && wakeState && autoSleep_reg && !energyLvl |=> !wakeState)
    else $error("no sleep without energy");
  manual_flip_a: assert property (enable_reg && manual_reg |=> wakeState != $past(wakeState))
    else $error("manual transition did not flip state");
  manual_clear_a: assert property (manual_reg && !wr |=> !manual_reg)
    else $error("manual bit did not self-clear");
  burst_start_a: assert property (wakeRise |-> firstPulse)
    else $error("no pulse after wake");
  // burst length follows the disable bit as it stood when the wake was taken
  burst_len_a: assert property (wakeRise |->
      burstLeft_reg == ($past(burstDis_reg) ? BURST_SINGLE : BURST_FULL))
    else $error("wrong burst length");
  state_read_a: assert property (rd |=> regRdData[STATE_BIT] == $past(wakeState))
    else $error("state bit mismatch");
  err_flag_a: assert property (errReach |=> errHit_reg ##1 (errHit_reg || $past(rd)))
    else $error("error flag not held");
  err_no_wake_a: assert property (enable_reg && !wakeState && errReach && !manual_reg && !dataReach
      |=> !wakeState)
    else $error("error threshold caused a wake");
  data_flag_a: assert property (dataReach |=> dataHit_reg)
    else $error("data flag not set on threshold");
  cor_clear_a: assert property (rd && !dataReach && !errReach |=> !dataHit_reg && !errHit_reg)
    else $error("flags not cleared by read");
  idle_reset_a: assert property (idleTimeout |=> dataCount == '0 && errCount == '0)
    else $error("counters not reset after idle");
  reset_thr_a: assert property (@(posedge clk) disable iff (1'b0)
      !resetn |=> errThr_reg == ERR_THR_RST && dataThr_reg == DATA_THR_RST)
    else $error("threshold reset values wrong");

endmodule

`default_nettype wire

/* edpc_pkg.sv */
/*
  Shared constants and types for the energy detect power control block.
  Assumes a single 20 MHz clock and a management port that has already
  decoded its serial framing into address, strobes and 16-bit data.
*/
`default_nettype none

package edpc_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int THR_W  = 4;

  localparam logic [ADDR_W-1:0] EDC_ADDR = 5'h1D;

  localparam int EN_BIT        = 15;
  localparam int AUTO_WAKE_BIT = 14;
  localparam int AUTO_SLEEP_BIT = 13;
  localparam int MAN_BIT       = 12;
  localparam int BURST_DIS_BIT = 11;
  localparam int STATE_BIT     = 10;
  localparam int ERR_HIT_BIT   = 9;
  localparam int DATA_HIT_BIT  = 8;
  localparam int ERR_THR_MSB   = 7;
  localparam int ERR_THR_LSB   = 4;
  localparam int DATA_THR_MSB  = 3;
  localparam int DATA_THR_LSB  = 0;

  localparam logic             EN_RST         = 1'h0;
  localparam logic             AUTO_WAKE_RST  = 1'h1;
  localparam logic             AUTO_SLEEP_RST = 1'h1;
  localparam logic             BURST_DIS_RST  = 1'h0;
  localparam logic [THR_W-1:0] ERR_THR_RST    = 4'h1;
  localparam logic [THR_W-1:0] DATA_THR_RST   = 4'h1;

  localparam logic [2:0] BURST_FULL   = 3'h4;
  localparam logic [2:0] BURST_SINGLE = 3'h1;

  localparam int CLK_FREQ_HZ       = 20_000_000;
  localparam int IDLE_RESET_S      = 2;
  localparam int IDLE_RESET_CYCLES = CLK_FREQ_HZ * IDLE_RESET_S;
  localparam int PULSE_GAP_CYCLES  = 16;

  typedef enum logic {ST_ASLEEP, ST_AWAKE} edpc_state_t;

endpackage

`default_nettype wire

/* edpc_event_counter.sv */
/*
  Saturating event counter with threshold detect.
  Assumes eventIn is a one-cycle pulse already in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module edpc_event_counter
#(
  parameter int WIDTH = 4
)
(
  input  wire logic             clk,       // system clock
  input  wire logic             resetn,    // sync reset, active low
  input  wire logic             clear,     // zero the count
  input  wire logic             eventIn,   // one event
  input  wire logic [WIDTH-1:0] threshold, // count that triggers
  output logic      [WIDTH-1:0] count,     // current count
  output logic                  reach      // event met threshold
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH-1:0] countInc;

  always_comb
  begin
    countInc = (count_reg == {WIDTH{1'b1}}) ? count_reg : count_reg + WIDTH'(1);
    count_next = count_reg;
    reach = 1'b0;
    if (clear)
    begin
      count_next = '0;
    end
    else if (eventIn)
    begin
      count_next = countInc;
      reach = (countInc >= threshold);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;

endmodule

`default_nettype wire

/* edpc_line_model.sv */
/*
  Twisted-pair far side: drives line detector pins, counts wake pulses.
  Assumes the bench calls its tasks and that pins change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module edpc_line_model
(
  input  wire logic clk,           // 20 MHz clock
  input  wire logic edPulse,       // pulse sent by the block
  output var  logic edDataPin,     // data event pin
  output var  logic edErrPin,      // error event pin
  output var  logic lineEnergyPin  // energy level on line
);
  int pulseCount;

  initial
  begin
    edDataPin     = 1'b0;
    edErrPin      = 1'b0;
    lineEnergyPin = 1'b1;
    pulseCount    = 0;
  end

  // pulses leaving the block on the line
  always @(posedge clk)
  begin
    if (edPulse === 1'b1)
      pulseCount <= pulseCount + 1;
  end

  // one event: high two cycles, low two cycles
  task automatic lineEvent(input bit isErr);
    @(negedge clk);
    if (isErr)
      edErrPin = 1'b1;
    else
      edDataPin = 1'b1;
    repeat (2) @(negedge clk);
    edErrPin  = 1'b0;
    edDataPin = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic setEnergy(input logic level);
    @(negedge clk);
    lineEnergyPin = level;
  endtask
endmodule

`default_nettype wire

/* energy_detect_power_control_test.sv */
/*
  Self-checking bench for the energy detect power control block.
  Assumes strobe register port and the line model in edpc_line_model.sv.
*/
`timescale 1ns/1ps
`default_nettype none

module energy_detect_power_control_test;
  import edpc_pkg::*;

  logic        clk;
  logic        resetn;
  logic [4:0]  regAddr;
  logic        regWrEn;
  logic        regRdEn;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic        wakeState;
  logic        edPulse;
  wire         edDataPin;
  wire         edErrPin;
  wire         lineEnergyPin;
  int          numErrors;
  int          cmpCount;

  edpc_top #(.IDLE_CYCLES(200), .PULSE_GAP(4)) dut
  (
    .clk           (clk),
    .resetn        (resetn),
    .edDataPin     (edDataPin),
    .edErrPin      (edErrPin),
    .lineEnergyPin (lineEnergyPin),
    .regAddr       (regAddr),
    .regWrEn       (regWrEn),
    .regRdEn       (regRdEn),
    .regWrData     (regWrData),
    .regRdData     (regRdData),
    .wakeState     (wakeState),
    .edPulse       (edPulse)
  );

  edpc_line_model line
  (
    .clk           (clk),
    .edPulse       (edPulse),
    .edDataPin     (edDataPin),
    .edErrPin      (edErrPin),
    .lineEnergyPin (lineEnergyPin)
  );

  always #25 clk = ~clk;

  task automatic testDone();
    $display("compares %0d, errors %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic regWrite(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clk);
    regWrEn   = 1'b0;
  endtask

  task automatic regRead(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    chk("register read", exp, regRdData);
  endtask

  // bounded wait for the power state to settle
  task automatic waitState(input logic exp);
    for (int i = 0; i < 12 && wakeState !== exp; i++)
      @(negedge clk);
    chk("wake state", {15'h0000, exp}, {15'h0000, wakeState});
  endtask

  task automatic events(input int n, input bit isErr);
    repeat (n) line.lineEvent(isErr);
    repeat (3) @(negedge clk);
  endtask

  initial
  begin
    clk       = 1'b0;
    resetn    = 1'b0;
    regAddr   = 5'h00;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regWrData = 16'h0000;
    numErrors = 0;
    cmpCount  = 0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    regRead(5'h1D, 16'h6011);
    regRead(5'h1C, 16'h0000);
    events(1, 1'b0);
    waitState(1'b0);
    regRead(5'h1D, 16'h6011);
    regWrite(5'h1D, 16'h8002);
    events(1, 1'b0);
    repeat (210) @(negedge clk);
    events(1, 1'b0);
    regRead(5'h1D, 16'h8002);
    events(1, 1'b0);
    regRead(5'h1D, 16'h8102);
    regRead(5'h1D, 16'h8002);
    chk("no auto wake", 16'h0000, {15'h0000, wakeState});
    repeat (210) @(negedge clk);
    regWrite(5'h1D, 16'hE023);
    line.pulseCount = 0;
    events(2, 1'b0);
    chk("below threshold", 16'h0000, {15'h0000, wakeState});
    events(1, 1'b0);
    waitState(1'b1);
    repeat (40) @(negedge clk);
    chk("burst pulses", 16'h0004, line.pulseCount[15:0]);
    regRead(5'h1D, 16'hE523);
    events(2, 1'b1);
    regRead(5'h1D, 16'hE623);
    regRead(5'h1D, 16'hE423);
    line.setEnergy(1'b0);
    waitState(1'b0);
    regRead(5'h1D, 16'hE023);
    events(2, 1'b1);
    chk("error no wake", 16'h0000, {15'h0000, wakeState});
    regRead(5'h1D, 16'hE223);
    line.setEnergy(1'b1);
    repeat (210) @(negedge clk);
    line.pulseCount = 0;
    regWrite(5'h1D, 16'hF823);
    waitState(1'b1);
    repeat (40) @(negedge clk);
    chk("single pulse", 16'h0001, line.pulseCount[15:0]);
    regRead(5'h1D, 16'hEC23);
    regWrite(5'h1D, 16'hFF23);
    waitState(1'b0);
    regRead(5'h1D, 16'hE823);
    regWrite(5'h1C, 16'h0000);
    regRead(5'h1D, 16'hE823);
    testDone();
  end

  initial
  begin
    #(50 * 5000);
    numErrors++;
    testDone();
  end
endmodule

`default_nettype wire
